// ===== src/startup_config_loader.sv
// Purpose: power-up configuration loading and strap capture
// Assumes: reset is synchronous to i_mclk; strap pins are asynchronous
// Notes:   a one-time-programmed image replaces defaults when present
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "cfg_loader_defines.svh"

module startup_config_loader
#(
  parameter int unsigned HOLD_CYC = `STRAP_HOLD_CYC
)
(
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  // board pins
  input  wire logic [5:0]             i_gpio,
  input  wire logic                   i_otp_valid,
  input  wire logic [7:0]             i_otp_data,
  output logic      [7:0]             o_otp_addr,
  // host register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  // status and controls
  output logic                        o_ready,
  output logic                        o_straps_released,
  output logic      [1:0]             o_mclk_sel,
  output logic                        o_mclk_valid,
  output logic                        o_host_i2c,
  output logic                        o_diff_output_zero_en,
  output logic      [7:0]             o_out_en
);

  // ==========================================================
  // pin synchronisers
  logic [5:0] gpio_s1_r;
  logic [5:0] gpio_s2_r;

  always_ff @(posedge i_mclk)
  begin
    gpio_s1_r <= i_gpio;
    gpio_s2_r <= gpio_s1_r;
  end

  // ==========================================================
  // load sequencer and hold window
  cfg_loader_pkg::load_state_e state_r;
  cfg_loader_pkg::load_state_e state_nxt;
  logic [7:0]                  idx_r;
  logic [7:0]                  idx_nxt;
  logic [31:0]                 hold_r;
  logic [31:0]                 hold_nxt;
  cfg_loader_pkg::strap_s      strap_r;
  cfg_loader_pkg::strap_s      strap_nxt;
  logic                        otp_used_r;
  logic                        otp_used_nxt;

  function automatic logic is_last(input logic [7:0] idx);
    is_last = (idx == 8'(`CFG_NUM_REGS - 1));
  endfunction

  always_comb
  begin
    state_nxt    = state_r;
    idx_nxt      = idx_r;
    hold_nxt     = hold_r;
    strap_nxt    = strap_r;
    otp_used_nxt = otp_used_r;
    case (state_r)
      cfg_loader_pkg::ST_LOAD:
      begin
        idx_nxt      = idx_r + 8'h01;
        otp_used_nxt = i_otp_valid;
        if (is_last(idx_r))
        begin
          state_nxt = cfg_loader_pkg::ST_HOLD;
          idx_nxt   = 8'h00;
        end
      end
      cfg_loader_pkg::ST_HOLD:
      begin
        // window counts from the end of the load walk; the board keeps straps steady
        hold_nxt = hold_r + 32'h1;
        if (hold_r + 32'h1 >= HOLD_CYC)
        begin
          state_nxt          = cfg_loader_pkg::ST_RUN;
          strap_nxt.mclk_sel = gpio_s2_r[1:0];
          strap_nxt.host_i2c = gpio_s2_r[3];
          strap_nxt.spare    = gpio_s2_r[5:4];
        end
      end
      cfg_loader_pkg::ST_RUN:
      begin
        state_nxt = cfg_loader_pkg::ST_RUN; // straps frozen until reset
      end
      default:
      begin
        state_nxt = cfg_loader_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      state_r    <= cfg_loader_pkg::ST_LOAD;
      idx_r      <= 8'h00;
      hold_r     <= 32'h0;
      strap_r    <= '0;
      otp_used_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      idx_r      <= idx_nxt;
      hold_r     <= hold_nxt;
      strap_r    <= strap_nxt;
      otp_used_r <= otp_used_nxt;
    end
  end

  assign o_otp_addr = idx_r;

  // ==========================================================
  // configuration bank
  cfg_loader_pkg::byte_t bank_r   [`CFG_NUM_REGS];
  cfg_loader_pkg::byte_t bank_nxt [`CFG_NUM_REGS];
  logic                  loading;
  logic                  host_ok;

  assign loading = (state_r == cfg_loader_pkg::ST_LOAD);
  // host writes are refused during the load walk, so loading never races them
  assign host_ok = !loading && (i_addr < 8'(`CFG_NUM_REGS));

  generate
    for (genvar g = 0; g < `CFG_NUM_REGS; g++)
    begin : g_bank
      always_comb
      begin
        bank_nxt[g] = bank_r[g];
        if (loading && idx_r == 8'(g))
          bank_nxt[g] = i_otp_valid ? i_otp_data : `CFG_DEFAULT_VAL;
        else if (i_wr && host_ok && i_addr == 8'(g)
                 && i_addr != `REG_STRAP_STAT && i_addr != `REG_LOAD_STAT)
          bank_nxt[g] = i_wdata;
      end

      always_ff @(posedge i_mclk)
      begin
        if (i_reset)
          bank_r[g] <= `CFG_DEFAULT_VAL; // volatile: reset discards host data
        else
          bank_r[g] <= bank_nxt[g];
      end
    end
  endgenerate

  // ==========================================================
  // read port
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (i_rd && host_ok)
    begin
      case (i_addr)
        `REG_STRAP_STAT: rdata_nxt = {3'h0, strap_r};
        `REG_LOAD_STAT:  rdata_nxt = {5'h0, otp_used_r, state_r};
        default:         rdata_nxt = bank_r[i_addr];
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign o_rdata = rdata_r;

  // ==========================================================
  // outputs
  logic running;
  logic diff0_r;
  logic diff0_nxt;

  assign running = (state_r == cfg_loader_pkg::ST_RUN);

  // pin 2 is sampled live so a pull-up alone lights the output
  assign diff0_nxt = !loading && (gpio_s2_r[2]
                     || bank_r[`REG_OUT_EN][`FLD_DIFF0_EN]);

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      diff0_r <= 1'b0;
    else
      diff0_r <= diff0_nxt;
  end

  assign o_ready               = !loading;
  assign o_straps_released     = running;
  assign o_mclk_sel            = strap_r.mclk_sel;
  assign o_mclk_valid          = running && strap_r.mclk_sel == `MCLK_SEL_24M576;
  assign o_host_i2c            = strap_r.host_i2c;
  assign o_diff_output_zero_en = diff0_r;
  assign o_out_en              = loading ? 8'h00 : bank_r[`REG_OUT_EN];

  // ==========================================================
  // checks
  logic host_wr0;

  assign host_wr0 = i_wr && host_ok && i_addr == `REG_OUT_EN;

  load_len_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(o_ready) |-> $past(idx_r) == 8'(`CFG_NUM_REGS - 1))
    else $error("load walk wrong length");

  load_step_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (loading && $past(loading) && !$past(i_reset)) |-> idx_r == $past(idx_r) + 8'h01)
    else $error("load walk skipped an index");

  out_off_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    loading |-> (o_out_en == 8'h00 && !o_diff_output_zero_en))
    else $error("output enabled during load");

  // only the load walk or a host write may change the enable byte
  out_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!loading && $changed(o_out_en)) |-> ($past(host_wr0) || $past(loading)))
    else $error("output enable changed without a write");

  diff0_strap_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!loading && gpio_s2_r[2]) |=> o_diff_output_zero_en)
    else $error("strap did not enable diff output");

  strap_frozen_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    running && $past(running) |-> $stable(strap_r))
    else $error("strap changed after capture");

  strap_release_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(o_straps_released) |-> $past(hold_r) == 32'(HOLD_CYC - 1))
    else $error("straps released at wrong time");

  strap_held_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_straps_released |-> hold_r == 32'(HOLD_CYC))
    else $error("straps released before window end");

  host_wr_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    host_wr0 |=> bank_r[`REG_OUT_EN] == $past(i_wdata))
    else $error("host write lost");

  rd_idle_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  ready_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $fell(o_ready) |-> $past(i_reset))
    else $error("ready dropped without reset");

  otp_load_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (loading && i_otp_valid) |=> bank_r[$past(idx_r)] == $past(i_otp_data))
    else $error("programmed value not loaded");

  host_sel_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(running) |-> o_host_i2c == $past(gpio_s2_r[3]))
    else $error("host interface strap mismatch");

  mclk_sel_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    $rose(running) |-> o_mclk_sel == $past(gpio_s2_r[1:0]))
    else $error("master clock strap mismatch");

  reset_clear_a: assert property (@(posedge i_mclk)
    i_reset |=> bank_r[`REG_OUT_EN] == `CFG_DEFAULT_VAL)
    else $error("reset kept host value");

  load_c:  cover property (@(posedge i_mclk) disable iff (i_reset) $rose(o_ready));
  run_c:   cover property (@(posedge i_mclk) disable iff (i_reset) $rose(running));
  wr_c:    cover property (@(posedge i_mclk) disable iff (i_reset) i_wr && host_ok);
  otp_c:   cover property (@(posedge i_mclk) disable iff (i_reset) loading && i_otp_valid);
  diff0_c: cover property (@(posedge i_mclk) disable iff (i_reset) $rose(o_diff_output_zero_en));

endmodule

// ===== inc/cfg_loader_defines.svh
// Purpose: constants for the startup configuration loader
// Assumes: 25 MHz master clock
// Notes:   offsets are register indices into the bank
`ifndef CFG_LOADER_DEFINES_SVH
`define CFG_LOADER_DEFINES_SVH

// ==========================================================
// bank geometry
`define CFG_NUM_REGS        253
`define CFG_ADDR_W          8
`define CFG_DATA_W          8

// ==========================================================
// timing
`define CLK_PERIOD_NS       40
`define STRAP_HOLD_MS       50
`define STRAP_HOLD_CYC      ((`STRAP_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

// ==========================================================
// register indices and fields
`define REG_OUT_EN          8'h00
`define REG_STRAP_STAT      8'h01
`define REG_LOAD_STAT       8'h02
`define FLD_DIFF0_EN        0
`define MCLK_SEL_24M576     2'h3

// ==========================================================
// default register value
`define CFG_DEFAULT_VAL     8'h00

`endif

// ===== inc/cfg_loader_pkg.sv
// Purpose: types for the startup configuration loader
// Assumes: nothing
// Notes:   none
package cfg_loader_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0]
  {
    ST_LOAD = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b11
  } load_state_e;

  typedef struct packed
  {
    logic [1:0] mclk_sel;
    logic       host_i2c;
    logic [1:0] spare;
  } strap_s;

endpackage

// ===== test/board_model.sv
// Purpose: board side model: strap resistors and otp image
// Assumes: bench sets straps before reset ends
// Notes:   released straps other than pin 2 show the inverse level, not the last one
`timescale 1ns/1ps
module board_model
(
  // controls
  input  wire logic       i_released,
  input  wire logic [5:0] i_strap,
  input  wire logic       i_otp_on,
  input  wire logic [7:0] i_otp_addr,
  // pins
  output logic      [5:0] o_gpio,
  output logic            o_otp_valid,
  output logic      [7:0] o_otp_data
);
  // ==========================================================
  // straps held until release; pin 2 stays a live level
  assign o_gpio = i_released ? {~i_strap[5:3], i_strap[2], ~i_strap[1:0]} : i_strap;
  assign o_otp_valid = i_otp_on;
  assign o_otp_data = i_otp_addr ^ 8'ha5;
endmodule

// ===== test/startup_config_loader_tb.sv
// Purpose: self-checking bench for the startup loader
// Assumes: short hold window parameter
// Notes:   straps flip after release to expose late capture
`timescale 1ns/1ps
module startup_config_loader_tb;
  localparam int HOLD = 20;
  logic       i_mclk, i_reset, i_otp_valid, i_wr, i_rd, otp_on;
  logic       o_ready, o_straps_released, o_mclk_valid, o_host_i2c, o_diff_output_zero_en;
  logic [1:0] o_mclk_sel;
  logic [5:0] i_gpio, strap;
  logic [7:0] i_otp_data, o_otp_addr, i_addr, i_wdata, o_rdata, o_out_en, rd_v;
  int         n_fail, n_checks;

  startup_config_loader #(.HOLD_CYC(HOLD)) dut (.i_mclk, .i_reset, .i_gpio, .i_otp_valid,
    .i_otp_data, .o_otp_addr, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ready,
    .o_straps_released, .o_mclk_sel, .o_mclk_valid, .o_host_i2c, .o_diff_output_zero_en,
    .o_out_en);
  board_model board (.i_released(o_straps_released), .i_strap(strap), .i_otp_on(otp_on),
    .i_otp_addr(o_otp_addr), .o_gpio(i_gpio), .o_otp_valid(i_otp_valid),
    .o_otp_data(i_otp_data));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    rd_v = o_rdata;
  endtask
  task automatic boot(input logic [5:0] s, input logic o);
    int k;
    strap <= s;
    otp_on <= o;
    i_reset <= 1'b1;
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    k = 0;
    while (o_straps_released !== 1'b1 && k < 600)
    begin
      @(posedge i_mclk);
      k++;
      // a write during the load walk must be refused
      if (k == 5)
      begin
        chk(o_out_en, 8'h00);
        chk({7'h0, o_ready}, 8'h00);
        i_wr <= 1'b1;
        i_addr <= 8'h00;
        i_wdata <= 8'h01;
      end
      if (k == 6)
        i_wr <= 1'b0;
      if (k == 253)
        chk({7'h0, o_ready}, 8'h00);
      if (k == 254)
        chk({7'h0, o_ready}, 8'h01);
    end
    chk({7'h0, k == 253 + HOLD + 1}, 8'h01);
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_straps(input logic [5:0] s);
    boot(s, 1'b0);
    chk({6'h0, o_mclk_sel}, {6'h0, s[1:0]});
    chk({7'h0, o_mclk_valid}, {7'h0, s[1:0] == 2'h3});
    chk({7'h0, o_host_i2c}, {7'h0, s[3]});
    chk({7'h0, o_diff_output_zero_en}, {7'h0, s[2]});
    chk(o_out_en, 8'h00);
    rd(8'h00);
    chk(rd_v, 8'h00);
    rd(8'h01);
    chk(rd_v, {3'h0, s[1:0], s[3], s[5:4]});
    rd(8'h02);
    chk(rd_v, 8'h03);
    rd(8'hfc);
    chk(rd_v, 8'h00);
  endtask
  task automatic t_host;
    wr(8'hfc, 8'h3c);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'hff);
    wr(8'hfd, 8'hff);
    rd(8'hfc);
    chk(rd_v, 8'h3c);
    rd(8'h00);
    chk(rd_v, 8'h01);
    chk(o_out_en, 8'h01);
    chk({7'h0, o_diff_output_zero_en}, 8'h01);
    rd(8'hfd);
    chk(rd_v, 8'h00);
    rd(8'h01);
    chk(rd_v, 8'h1c);
    boot(6'b001011, 1'b0);
    rd(8'hfc);
    chk(rd_v, 8'h00);
  endtask
  task automatic t_otp;
    boot(6'b001011, 1'b1);
    rd(8'h05);
    chk(rd_v, 8'ha0);
    rd(8'hfc);
    chk(rd_v, 8'h59);
    rd(8'h02);
    chk(rd_v, 8'h07);
    chk(o_out_en, 8'ha5);
    chk({7'h0, o_diff_output_zero_en}, 8'h01);
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial
  begin
    #(40 * 20000);
    n_fail++;
    stop_test();
  end
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    strap = 6'h00;
    otp_on = 1'b0;
    t_straps(6'b001011);
    t_straps(6'b110110);
    t_straps(6'b001011);
    t_host();
    t_otp();
    stop_test();
  end
endmodule
